// >>> include/cbsc_pkg.sv
// package: offsets, fields and types of the status-changed register set
package cbsc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_EVENT = 8'h80;
	localparam logic [7:0] OFF_MASK = 8'h84;
	localparam logic [7:0] OFF_STATE = 8'h88;
	localparam logic [7:0] OFF_FORCE = 8'h8c;
	localparam int BIT_WAKE = 4;
	localparam int BIT_SUMM = 14;
	localparam int BIT_INTR = 15;
	localparam logic RST_WAKE = 1'b0;
	localparam logic RST_INTR = 1'b0;
	localparam logic RST_EN = 1'b0;

	typedef struct packed {
		logic evWake;
		logic evIntr;
		logic enWake;
		logic enSumm;
		logic enIntr;
		logic psWake;
		logic [31:0] rdData;
	} cbsc_state_t;

	typedef enum logic [1:0] {
		CBSC_SEL_NONE = 2'h0,
		CBSC_SEL_EVENT = 2'h1,
		CBSC_SEL_MASK = 2'h3,
		CBSC_SEL_STATE = 2'h2
	} cbsc_sel_t;
endpackage

// >>> include/cbsc_dec_if.sv
// interface: decoded register access between decoder and register core
`timescale 1ns/10ps
interface cbsc_dec_if;
	import cbsc_pkg::*;
	logic wrEvent;
	logic wrMask;
	logic wrForce;
	cbsc_sel_t rdSel;
	modport dec (output wrEvent, output wrMask, output wrForce, output rdSel);
	modport core (input wrEvent, input wrMask, input wrForce, input rdSel);
endinterface

// >>> core/cbsc_decode.sv
// module: memory-space address decoder for the status-changed registers
`timescale 1ns/10ps
module cbsc_decode (
	input wire logic memSel,
	input wire logic ioSel,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [cbsc_pkg::ADDR_W-1:0] addr,
	cbsc_dec_if.dec bus
);
	import cbsc_pkg::*;
	logic hit;
	// io cycles never reach these registers
	assign hit = memSel & ~ioSel;
	always_comb begin
		bus.wrEvent = hit & wrEn & (addr == OFF_EVENT);
		bus.wrMask = hit & wrEn & (addr == OFF_MASK);
		bus.wrForce = hit & wrEn & (addr == OFF_FORCE);
		bus.rdSel = CBSC_SEL_NONE;
		if (hit & rdEn) begin
			case (addr)
				OFF_EVENT: bus.rdSel = CBSC_SEL_EVENT;
				OFF_MASK: bus.rdSel = CBSC_SEL_MASK;
				OFF_STATE: bus.rdSel = CBSC_SEL_STATE;
				default: bus.rdSel = CBSC_SEL_NONE;
			endcase
		end
	end
endmodule

// >>> core/cardbus_status_change_regs.sv
// module: status-changed register set with wake and interrupt gating
`timescale 1ns/10ps
// How it works
// - registers are decoded in memory space only, never in io space.
// - a power management event sets the latched wake bit 4 at 80h.
// - latched wake clears when the configuration pme status is cleared.
// - event bit 15 sets while any function interrupt is pending.
// - latched interrupt clears on write-one and on hardware/software reset.
// - the status change pin asserts for wake only if mask bits 4 and 14 set.
// - wake enable and summary enable clear on power-up reset.
// - mask bit 15 gates the interrupt pin and clears on hw/sw reset.
// - present bit 4 shows live wake, clearing with event bit or pme status.
// - present bit 15 shows live interrupt state, cleared at its source or by hw/sw reset.
// - force bit 4 written one sets latched wake, not present bit 4.
// - force bit 15 written one sets latched interrupt, not present bit 15.
module cardbus_status_change_regs (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic hwRst,
	input wire logic swRst,
	input wire logic memSel,
	input wire logic ioSel,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [cbsc_pkg::ADDR_W-1:0] addr,
	input wire logic [31:0] wrData,
	output logic [31:0] rdData,
	input wire logic pmeEvent,
	input wire logic pmeStatus,
	input wire logic pmeStatusClr,
	input wire logic pmeEnable,
	input wire logic intrPending,
	output logic cstschg,
	output logic intPin
);
	import cbsc_pkg::*;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	cbsc_dec_if decBus ();

	cbsc_decode uDec (
		.memSel(memSel),
		.ioSel(ioSel),
		.wrEn(wrEn),
		.rdEn(rdEn),
		.addr(addr),
		.bus(decBus)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cbsc_state_t st_ff;
	cbsc_state_t nxt_st;

	// ------------------------------------------------------------
	// reset classes
	// ------------------------------------------------------------
	logic pwrRst;
	logic otherRst;
	logic rstEvWake;
	logic rstEvIntr;
	logic rstEnWake;
	logic rstEnIntr;
	logic rstPsWake;
	logic rstRdData;

	// sys_rst is the power-up reset
	assign pwrRst = sys_rst;
	// hardware and software reset act alike here
	assign otherRst = hwRst | swRst;
	// each field listens only to its own reset classes
	assign rstEvWake = pwrRst;
	assign rstEvIntr = pwrRst | otherRst;
	assign rstEnWake = pwrRst;
	assign rstEnIntr = pwrRst | otherRst;
	assign rstPsWake = pwrRst | otherRst;
	assign rstRdData = pwrRst;

	// ------------------------------------------------------------
	// access strobes
	// ------------------------------------------------------------
	logic wrEvHit;
	logic wrMkHit;
	logic wrFcHit;

	// decoded strobes, io cycles already refused
	assign wrEvHit = decBus.wrEvent;
	assign wrMkHit = decBus.wrMask;
	// force register is write-only
	assign wrFcHit = decBus.wrForce;

	// ------------------------------------------------------------
	// event terms
	// ------------------------------------------------------------
	logic clrWake;
	logic clrIntr;
	logic frcWake;
	logic frcIntr;
	logic setWake;
	logic setIntr;
	logic pmeDrop;

	// write-one clears of the latched event bits
	assign clrWake = wrEvHit & wrData[BIT_WAKE];
	assign clrIntr = wrEvHit & wrData[BIT_INTR];
	// force writes of one; zeros do nothing
	assign frcWake = wrFcHit & wrData[BIT_WAKE];
	assign frcIntr = wrFcHit & wrData[BIT_INTR];
	// hardware sources of the events
	assign setWake = pmeEvent;
	assign setIntr = intrPending;
	// configuration pme status being cleared
	assign pmeDrop = pmeStatusClr;

	// ------------------------------------------------------------
	// mask terms
	// ------------------------------------------------------------
	logic mkLoad;
	logic mkWake;
	logic mkSumm;
	logic mkIntr;

	// a mask write replaces all three live bits at once
	assign mkLoad = wrMkHit;
	assign mkWake = wrData[BIT_WAKE];
	assign mkSumm = wrData[BIT_SUMM];
	assign mkIntr = wrData[BIT_INTR];

	// ------------------------------------------------------------
	// live state
	// ------------------------------------------------------------
	logic psIntr;
	logic wakeHeld;

	// live interrupt: cleared at its source or while hardware or software reset is asserted
	assign psIntr = intrPending & ~otherRst;
	// latched wake stays up unless cleared without a set
	assign wakeHeld = setWake | frcWake
		| (st_ff.evWake & ~clrWake & ~pmeDrop);

	// ------------------------------------------------------------
	// register words
	// ------------------------------------------------------------
	logic [31:0] evWord;
	logic [31:0] mkWord;
	logic [31:0] psWord;

	// only bits 4, 14 and 15 are live
	for (genvar gi = 0; gi < 32; gi++) begin : g_word
		if (gi == BIT_WAKE) begin : g_wake
			assign evWord[gi] = st_ff.evWake;
			assign mkWord[gi] = st_ff.enWake;
			assign psWord[gi] = st_ff.psWake;
		end else if (gi == BIT_SUMM) begin : g_summ
			assign evWord[gi] = 1'b0;
			assign mkWord[gi] = st_ff.enSumm;
			assign psWord[gi] = 1'b0;
		end else if (gi == BIT_INTR) begin : g_intr
			assign evWord[gi] = st_ff.evIntr;
			assign mkWord[gi] = st_ff.enIntr;
			assign psWord[gi] = psIntr;
		end else begin : g_rsvd
			// reserved bits read as zero
			assign evWord[gi] = 1'b0;
			assign mkWord[gi] = 1'b0;
			assign psWord[gi] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// read select
	// ------------------------------------------------------------
	logic [31:0] rdWord;

	// unmapped, write-only and refused cycles select zero
	always_comb begin
		case (decBus.rdSel)
			CBSC_SEL_EVENT: begin
				rdWord = evWord;
			end
			CBSC_SEL_MASK: begin
				rdWord = mkWord;
			end
			CBSC_SEL_STATE: begin
				rdWord = psWord;
			end
			default: begin
				rdWord = 32'h0000_0000;
			end
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// latched wake: clears first, so a set in the same cycle wins
		if (clrWake) begin
			nxt_st.evWake = 1'b0;
		end
		if (pmeDrop) begin
			nxt_st.evWake = 1'b0;
		end

		if (setWake) begin
			nxt_st.evWake = 1'b1;
		end

		if (frcWake) begin
			nxt_st.evWake = 1'b1;
		end

		// latched interrupt: clear, then sets
		if (clrIntr) begin
			nxt_st.evIntr = 1'b0;
		end

		if (setIntr) begin
			nxt_st.evIntr = 1'b1;
		end

		if (frcIntr) begin
			nxt_st.evIntr = 1'b1;
		end

		// live wake: follows events, drops with latch or pme status
		if (setWake) begin
			nxt_st.psWake = 1'b1;
		end else if (~wakeHeld | ~pmeStatus) begin
			nxt_st.psWake = 1'b0;
		end

		// mask register
		if (mkLoad) begin
			nxt_st.enWake = mkWake;
			nxt_st.enSumm = mkSumm;
			nxt_st.enIntr = mkIntr;
		end

		// read data is registered
		nxt_st.rdData = rdWord;

		// resets last, each by its own class
		// hardware and software reset leave the latched wake alone
		if (rstEvWake) begin
			nxt_st.evWake = RST_WAKE;
		end

		if (rstEvIntr) begin
			nxt_st.evIntr = RST_INTR;
		end

		if (rstEnWake) begin
			nxt_st.enWake = RST_EN;
			nxt_st.enSumm = RST_EN;
		end

		// interrupt enable drops on every reset class
		if (rstEnIntr) begin
			nxt_st.enIntr = RST_EN;
		end

		if (rstPsWake) begin
			nxt_st.psWake = 1'b0;
		end

		if (rstRdData) begin
			nxt_st.rdData = 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		st_ff <= nxt_st;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic wakeArm;
	logic intrArm;

	assign rdData = st_ff.rdData;

	// both mask bits arm the status change pin
	assign wakeArm = st_ff.enWake & st_ff.enSumm;
	// pme enable gate is the host's to drop as well
	assign cstschg = st_ff.evWake & wakeArm & pmeEnable;

	// mask bit 15 arms the interrupt pin
	assign intrArm = st_ff.enIntr;
	assign intPin = st_ff.evIntr & intrArm & psIntr;
endmodule

// >>> tb/cbsc_host_model.sv
// partner: configuration-space power status kept by system software
`timescale 1ns/10ps
module cbsc_host_model (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic pmeEvent,
	input wire logic clrReq,
	output logic pmeStatus,
	output logic pmeStatusClr
);
	always_ff @(posedge mclk) begin
		pmeStatus <= !sys_rst && !clrReq && (pmeEvent || pmeStatus);
		pmeStatusClr <= !sys_rst && clrReq && pmeStatus;
	end
endmodule

// >>> tb/cbsc_properties.sv
// checker: port properties of the status-changed register set
`timescale 1ns/10ps
module cbsc_properties (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic hwRst,
	input wire logic swRst,
	input wire logic memSel,
	input wire logic ioSel,
	input wire logic rdEn,
	input wire logic [cbsc_pkg::ADDR_W-1:0] addr,
	input wire logic [31:0] rdData,
	input wire logic pmeEvent,
	input wire logic pmeEnable,
	input wire logic intrPending,
	input wire logic cstschg,
	input wire logic intPin
);
	wire noRst = !hwRst && !swRst;
	wire rdOk = memSel && !ioSel && rdEn && noRst;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_io_read_zero: assert property (
		ioSel && rdEn |=> !rdData) else $error("io read");
	a_idle_read_zero: assert property (
		!rdEn |=> !rdData) else $error("idle read");
	a_wake_sets: assert property (
		pmeEvent ##1 (rdOk && addr == 8'h80) |=> rdData[4]) else $error("wake");
	a_intr_sets: assert property (
		(intrPending && noRst) ##1 (rdOk && addr == 8'h80) |=> rdData[15])
		else $error("intr");
	a_state_live: assert property (
		rdOk && addr == 8'h88 |=> rdData[15] == $past(intrPending))
		else $error("state");
	a_intr_gate: assert property (
		intPin |-> intrPending && noRst) else $error("int pin");
	a_intr_reset: assert property (
		!noRst |=> !intPin) else $error("int reset");
	a_wake_gate: assert property (
		cstschg |-> pmeEnable) else $error("wake pin");
endmodule
bind cardbus_status_change_regs cbsc_properties cbsc_properties_i (.mclk,
	.sys_rst, .hwRst, .swRst, .memSel, .ioSel, .rdEn, .addr, .rdData,
	.pmeEvent, .pmeEnable, .intrPending, .cstschg, .intPin);

// >>> tb/test_cardbus_status_change_regs.sv
// testbench: directed scenarios for the status-changed register set
`timescale 1ns/10ps
module test_cardbus_status_change_regs;
	import cbsc_pkg::*;
	logic mclk = 0, sys_rst = 1, hwRst = 0, swRst = 0, ioSel = 0, wrEn = 0;
	logic rdEn = 0, pmeEvent = 0, pmeEnable = 0, intrPending = 0, clrReq = 0;
	logic memSel = 1;
	logic pmeStatus, pmeStatusClr, cstschg, intPin;
	logic [ADDR_W-1:0] addr = 8'h0;
	logic [31:0] wrData = 32'h0, rdData;
	int badCount = 0, checks = 0;
	cardbus_status_change_regs cardbus_status_change_regs_i (.mclk, .sys_rst,
		.hwRst, .swRst, .memSel, .ioSel, .wrEn, .rdEn, .addr, .wrData,
		.rdData, .pmeEvent, .pmeStatus, .pmeStatusClr, .pmeEnable,
		.intrPending, .cstschg, .intPin);
	cbsc_host_model cbsc_host_model_i (.mclk, .sys_rst, .pmeEvent, .clrReq,
		.pmeStatus, .pmeStatusClr);
	initial forever #20 mclk = ~mclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one bus cycle; a read compares against d
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{wrEn, rdEn, addr, wrData} <= {w, !w, a, w ? d : 32'h0};
		@(posedge mclk);
		{wrEn, rdEn} <= 2'h0;
		#1 if (!w) chk(rdData, d);
	endtask
	task automatic wake;
		acc(0, OFF_MASK, 32'h0);
		pmeEvent <= 1'b1;
		acc(0, OFF_EVENT, 32'h10);
		acc(1, OFF_EVENT, 32'h10);
		acc(0, OFF_EVENT, 32'h10);
		pmeEvent <= 1'b0;
		acc(0, OFF_STATE, 32'h10);
		acc(1, OFF_MASK, 32'h4010);
		pmeEnable <= 1'b1;
		#1 chk(32'(cstschg), 32'h1);
		pmeEnable <= 1'b0;
		#1 chk(32'(cstschg), 32'h0);
		hwRst <= 1'b1;
		@(posedge mclk) hwRst <= 1'b0;
		acc(0, OFF_MASK, 32'h4010);
		ioSel <= 1'b1;
		acc(1, OFF_EVENT, 32'h10);
		acc(0, OFF_EVENT, 32'h0);
		ioSel <= 1'b0;
		memSel <= 1'b0;
		acc(1, OFF_EVENT, 32'h10);
		acc(0, OFF_EVENT, 32'h0);
		memSel <= 1'b1;
		acc(0, OFF_EVENT, 32'h10);
		acc(1, OFF_EVENT, 32'h10);
		acc(0, OFF_EVENT, 32'h0);
		acc(0, OFF_STATE, 32'h0);
		$display("wake done");
	endtask
	task automatic forced;
		acc(1, OFF_FORCE, 32'h8010);
		acc(0, OFF_EVENT, 32'h8010);
		acc(0, OFF_STATE, 32'h0);
		clrReq <= 1'b1;
		@(posedge mclk) clrReq <= 1'b0;
		acc(0, OFF_EVENT, 32'h8000);
		acc(1, OFF_EVENT, 32'h8000);
		acc(0, OFF_EVENT, 32'h0);
		$display("force done");
	endtask
	task automatic intr;
		intrPending <= 1'b1;
		acc(0, OFF_EVENT, 32'h8000);
		chk(32'(intPin), 32'h0);
		acc(1, OFF_MASK, 32'h8000);
		acc(0, OFF_STATE, 32'h8000);
		chk(32'(intPin), 32'h1);
		swRst <= 1'b1;
		@(posedge mclk) swRst <= 1'b0;
		intrPending <= 1'b0;
		acc(0, OFF_EVENT, 32'h0);
		acc(0, OFF_MASK, 32'h0);
		$display("intr done");
	endtask
	task automatic powerup;
		acc(1, OFF_FORCE, 32'h10);
		acc(1, OFF_MASK, 32'h4010);
		sys_rst <= 1'b1;
		@(posedge mclk) sys_rst <= 1'b0;
		acc(0, OFF_EVENT, 32'h0);
		acc(0, OFF_MASK, 32'h0);
		$display("powerup done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		wake;
		forced;
		intr;
		powerup;
		results;
	end
endmodule
